// ===== sam_pkg.sv
`default_nettype none
package sam_pkg;
  // ==========================================
  // Widths and sequencing
  localparam int unsigned FACTOR_W = 8;
  localparam int unsigned PROD_W = 16;
  localparam int unsigned SEQ_W = 4;
  localparam logic [3:0] SEQ_IDLE = 4'h0;
  localparam logic [3:0] SEQ_FIRST = 4'h8;
  localparam logic [3:0] SEQ_TERM = 4'hF;
  localparam logic [15:0] PROD_RESET = 16'h0000;
  localparam int unsigned LATENCY_CYCLES = 10;

  typedef enum logic [1:0] {
    SAM_IDLE = 2'b00,
    SAM_LOAD = 2'b01,
    SAM_STEP = 2'b10
  } sam_phase_t;

  typedef struct packed {
    sam_phase_t phase;
    logic [3:0] seq;
    logic [15:0] prod;
    logic ready_flag;
    logic busy;
    logic start_prev;
  } sam_state_t;
endpackage
`default_nettype wire

// ===== sam_multiplier.sv
// Contract
// RQ1: 8x8 shift-add product, ten clocks after start
// RQ2: Free clock; ready marks valid product
// RQ3: Idle: counter at zero, register held
// RQ4: Host requests by start high-to-low edge
// RQ5: First edge: clear ready, set busy, load
// RQ6: Next edge: counter eight, capture A, clear
// RQ7: Eight steps: count up, shift low byte
// RQ8: Multiplier bit zero: plain right shift
// RQ9: Multiplier bit one: add B, shift right
// RQ10: Counter fifteen: set ready, drop busy
// RQ11: Wide variant doubles counter, adder, register
// RQ12: Starts ignored while busy
`default_nettype none
module sam_multiplier
  import sam_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic start,
  input wire logic [7:0] factor_a,
  input wire logic [7:0] factor_b,
  output logic [15:0] product,
  output logic ready_flag,
  output logic busy,
  output logic parallel_load_enable,
  output logic master_clear,
  output logic terminal_count_flag
);
  // ==========================================
  // State
  sam_state_t st;
  sam_state_t next_st;
  logic start_fall;
  logic [8:0] sum;

  // Fixed 8x8; the wide variant adds a counter stage and doubles datapath, see RQ11
  assign start_fall = st.start_prev && !start; // see RQ4
  assign sum = {1'b0, st.prod[15:8]} + {1'b0, factor_b}; // see RQ9

  always_comb begin
    next_st = st;
    next_st.start_prev = start;
    unique case (st.phase)
      SAM_IDLE: begin
        // Register held: no write while idle, see RQ3
        next_st.seq = SEQ_IDLE;
        if (start_fall) begin // see RQ12
          next_st.phase = SAM_LOAD;
          next_st.ready_flag = 1'b0; // see RQ5
          next_st.busy = 1'b1;
        end
      end
      SAM_LOAD: begin
        next_st.seq = SEQ_FIRST; // see RQ6
        next_st.prod = {8'h00, factor_a};
        next_st.phase = SAM_STEP;
      end
      SAM_STEP: begin
        next_st.seq = st.seq + 4'h1; // see RQ7
        if (st.prod[0]) begin
          next_st.prod = {sum, st.prod[7:1]}; // see RQ9
        end else begin
          next_st.prod = {1'b0, st.prod[15:1]}; // see RQ8
        end
        if (st.seq == SEQ_TERM) begin
          // Terminal count closes the cycle; wrap returns to zero, see RQ10
          // Eighth step still runs here, so the product lands with ready
          next_st.seq = SEQ_IDLE;
          next_st.phase = SAM_IDLE;
          next_st.ready_flag = 1'b1;
          next_st.busy = 1'b0;
        end
      end
      default: next_st.phase = SAM_IDLE;
    endcase
  end

  // Reset comes up idle with ready set and an all-zero product
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st <= '{phase: SAM_IDLE, seq: SEQ_IDLE, prod: PROD_RESET,
              ready_flag: 1'b1, busy: 1'b0, start_prev: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign product = st.prod; // see RQ2
  assign ready_flag = st.ready_flag;
  assign busy = st.busy;
  assign parallel_load_enable = (st.phase == SAM_LOAD); // see RQ5
  assign master_clear = (st.phase == SAM_LOAD);
  assign terminal_count_flag = (st.seq == SEQ_TERM);

  // ==========================================
  // Checks
  property p_idle_hold;
    @(posedge core_clk) disable iff (!resetn)
      (st.phase == SAM_IDLE && !start_fall) |=> $stable(product) && !busy && st.seq == 4'h0;
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("idle changed state"); // see RQ3

  property p_start_busy;
    @(posedge core_clk) disable iff (!resetn)
      (st.phase == SAM_IDLE && start_fall) |=> busy && !ready_flag && parallel_load_enable;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("start not taken"); // see RQ5

  property p_load;
    @(posedge core_clk) disable iff (!resetn)
      parallel_load_enable |=> st.seq == 4'h8 && product == {8'h00, $past(factor_a)};
  endproperty
  a_load: assert property (p_load) else $error("load wrong"); // see RQ6

  property p_count;
    @(posedge core_clk) disable iff (!resetn)
      (st.phase == SAM_STEP && st.seq != 4'hF) |=> st.seq == $past(st.seq) + 4'h1;
  endproperty
  a_count: assert property (p_count) else $error("counter did not step"); // see RQ7

  property p_shift0;
    @(posedge core_clk) disable iff (!resetn)
      (st.phase == SAM_STEP && !product[0])
        |=> product == {1'b0, $past(product[15:1])};
  endproperty
  a_shift0: assert property (p_shift0) else $error("plain shift wrong"); // see RQ8

  property p_add1;
    @(posedge core_clk) disable iff (!resetn)
      (st.phase == SAM_STEP && product[0])
        |=> product == {$past(sum), $past(product[7:1])};
  endproperty
  a_add1: assert property (p_add1) else $error("add step wrong"); // see RQ9

  property p_done;
    @(posedge core_clk) disable iff (!resetn)
      terminal_count_flag |=> ready_flag && !busy;
  endproperty
  a_done: assert property (p_done) else $error("done not flagged"); // see RQ10

  property p_latency;
    @(posedge core_clk) disable iff (!resetn)
      (st.phase == SAM_IDLE && start_fall) |=> busy [*8] ##1 busy ##1 (ready_flag && !busy)
        ##0 product == $past(factor_a, 9) * $past(factor_b, 1);
  endproperty
  a_latency: assert property (p_latency) else $error("product late or wrong"); // see RQ1

  property p_ignore;
    @(posedge core_clk) disable iff (!resetn)
      (busy && !terminal_count_flag) |=> busy;
  endproperty
  a_ignore: assert property (p_ignore) else $error("busy dropped early"); // see RQ12

  // ==========================================
  // Checks on counter, flags and handshake
  property p_load_once;
    @(posedge core_clk) disable iff (!resetn)
      parallel_load_enable |=> !parallel_load_enable && busy && product[15:8] == 8'h00;
  endproperty
  a_load_once: assert property (p_load_once) else $error("load not single"); // see RQ6

  property p_clear_with_load;
    @(posedge core_clk) disable iff (!resetn)
      master_clear |-> parallel_load_enable && busy && !ready_flag;
  endproperty
  a_clear_with_load: assert property (p_clear_with_load) else $error("clear out of step"); // see RQ5

  property p_low_shift;
    @(posedge core_clk) disable iff (!resetn)
      (st.phase == SAM_STEP) |=> product[6:0] == $past(product[7:1]);
  endproperty
  a_low_shift: assert property (p_low_shift) else $error("low byte not shifted"); // see RQ7

  property p_step_count;
    @(posedge core_clk) disable iff (!resetn)
      parallel_load_enable |=> busy [*8] ##1 !busy;
  endproperty
  a_step_count: assert property (p_step_count) else $error("step count wrong"); // see RQ7

  property p_seq_range;
    @(posedge core_clk) disable iff (!resetn)
      (busy && !parallel_load_enable) |-> st.seq >= SEQ_FIRST;
  endproperty
  a_seq_range: assert property (p_seq_range) else $error("counter out of range"); // see RQ7

  property p_idle_seq;
    @(posedge core_clk) disable iff (!resetn)
      !busy |-> st.phase == SAM_IDLE && st.seq == SEQ_IDLE;
  endproperty
  a_idle_seq: assert property (p_idle_seq) else $error("idle counter not zero"); // see RQ3

  property p_ready_hold;
    @(posedge core_clk) disable iff (!resetn)
      (ready_flag && !start_fall) |=> ready_flag && $stable(product);
  endproperty
  a_ready_hold: assert property (p_ready_hold) else $error("ready result lost"); // see RQ2

  property p_busy_excl;
    @(posedge core_clk) disable iff (!resetn)
      busy |-> !ready_flag;
  endproperty
  a_busy_excl: assert property (p_busy_excl) else $error("ready while busy"); // see RQ2

  property p_tc_busy;
    @(posedge core_clk) disable iff (!resetn)
      terminal_count_flag |-> busy && st.phase == SAM_STEP;
  endproperty
  a_tc_busy: assert property (p_tc_busy) else $error("terminal count outside steps"); // see RQ10

  property p_term_wrap;
    @(posedge core_clk) disable iff (!resetn)
      terminal_count_flag |=> st.seq == SEQ_IDLE && !terminal_count_flag;
  endproperty
  a_term_wrap: assert property (p_term_wrap) else $error("counter did not wrap"); // see RQ10

  property p_ignore_start;
    @(posedge core_clk) disable iff (!resetn)
      (busy && start_fall) |=> !parallel_load_enable;
  endproperty
  a_ignore_start: assert property (p_ignore_start) else $error("start taken while busy"); // see RQ12
endmodule
`default_nettype wire

// ===== sam_host.sv
`default_nettype none
module sam_host (
  input wire logic req,
  input wire logic [7:0] a_in,
  input wire logic [7:0] b_in,
  output logic start,
  output logic [7:0] factor_a,
  output logic [7:0] factor_b
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // Start idles high, a request pulls it low
  assign start = ~req;
  assign factor_a = a_in;
  assign factor_b = b_in;
endmodule
`default_nettype wire

// ===== shift_add_binary_multiplier_tb_top.sv
`default_nettype none
module shift_add_binary_multiplier_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic req = 1'b0;
  logic [7:0] a_in = 8'h00;
  logic [7:0] b_in = 8'h00;
  logic start, ready_flag, busy, parallel_load_enable, master_clear, terminal_count_flag;
  logic [7:0] factor_a, factor_b;
  logic [15:0] product;
  logic [15:0] pairs [6] = '{16'h0000, 16'hFFFF, 16'hA53C, 16'h01FF, 16'h8002, 16'h7F81};
  int num_errors = 0;
  int checks_done = 0;
  always #2.5 core_clk = ~core_clk;
  sam_host host_u (.req, .a_in, .b_in, .start, .factor_a, .factor_b);
  sam_multiplier dut_u (.core_clk, .resetn, .start, .factor_a, .factor_b, .product,
    .ready_flag, .busy, .parallel_load_enable, .master_clear, .terminal_count_flag);
  // ==========
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Spam drops start again mid-run; it must not disturb the product
  task automatic mul(input logic [7:0] a, input logic [7:0] b, input logic spam);
    @(negedge core_clk);
    a_in = a;
    b_in = b;
    req = 1'b1;
    @(negedge core_clk);
    req = 1'b0;
    check({busy, ready_flag, parallel_load_enable, master_clear}, 16'h000B);
    repeat (4) @(negedge core_clk);
    req = spam;
    @(negedge core_clk);
    req = 1'b0;
    repeat (3) @(negedge core_clk);
    check({busy, terminal_count_flag}, 16'h0003);
    @(negedge core_clk);
    check({ready_flag, busy}, 16'h0002);
    check(product, 16'(a) * 16'(b));
  endtask
  // ==========
  initial begin
    repeat (4) @(negedge core_clk);
    resetn = 1'b1;
    @(negedge core_clk);
    check({ready_flag, busy}, 16'h0002);
    for (int i = 0; i < 6; i++) begin
      mul(pairs[i][15:8], pairs[i][7:0], i[0]);
      $display("Test %0d done", i);
    end
    a_in = 8'h5A;
    repeat (5) @(negedge core_clk);
    check(product, 16'h3FFF);
    check({busy, terminal_count_flag}, 16'h0000);
    $display("Idle test done");
    tally_and_finish();
  end
  initial begin
    #2000;
    num_errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
